// [hdl/embps_defines.svh]
`ifndef EMBPS_DEFINES_SVH
`define EMBPS_DEFINES_SVH

// ----------------------------------------
// Bus widths and field positions
// ----------------------------------------
`define EMBPS_ADDR_W        26
`define EMBPS_DATA_W        32
`define EMBPS_LANES         4
`define EMBPS_CS_W          6
`define EMBPS_CS_SDRAM_LO   2
`define EMBPS_CS_ACK        4
`define EMBPS_BOOT_W        4
`define EMBPS_BOOT_RSVD     3
`define EMBPS_FLAT_LSB      16
`define EMBPS_FLAT_W        5
`define EMBPS_ILV_LSB       21
`define EMBPS_ILV_W         4
`define EMBPS_RC_W          12
`define EMBPS_RC_SHARED_W   10
`define EMBPS_RC_A_LSB      1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EMBPS_RST_SDRAM_CS_SEL 2'h3
`define EMBPS_RST_BOOT         4'h0

`endif

// [hdl/embps_pkg.sv]
package embps_pkg;

  typedef enum logic [1:0] {
    EMBPS_OWNER_MEM,
    EMBPS_OWNER_SDRAM,
    EMBPS_OWNER_CARD
  } embps_owner_t;

  typedef enum logic {
    EMBPS_BANK_FLAT,
    EMBPS_BANK_INTERLEAVED
  } embps_bank_mode_t;

  // Requests from the memory, SDRAM and card controllers
  typedef struct packed {
    logic [3:0]  byte_lane_enable_n;
    logic        oe_n;
    logic        rw;
    logic [5:0]  cs_n;
    logic        burst_addr_latch_n;
    logic        burst_active;
    logic [25:0] addr;
  } embps_mem_req_t;

  typedef struct packed {
    logic [3:0]  dqm;
    logic [1:0]  sdram_chip_select_n;
    logic [4:0]  sdram_bank_sel_flat;
    logic [3:0]  sdram_bank_sel_interleaved;
    logic [11:0] sdram_row_col_addr;
    embps_bank_mode_t bank_mode;
  } embps_sdram_req_t;

  typedef struct packed {
    logic reg_n;
    logic iord_n;
    logic iowr_n;
    logic we_n;
  } embps_card_req_t;

  // Pin side
  typedef struct packed {
    logic [3:0]  byte_lane_enable_n;
    logic        oe_n;
    logic        rw;
    logic [5:0]  cs_n;
    logic [5:0]  cs_oe;
    logic        burst_addr_latch_n;
    logic        burst_clk;
    logic [25:0] addr;
  } embps_pins_t;

endpackage : embps_pkg

// [hdl/embps_sync.sv]
module embps_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // ----------------------------------------
  // Two-stage synchroniser per bit
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          meta_r[i] <= 1'b1;
          dout[i]   <= 1'b1;
        end
        else
        begin
          meta_r[i] <= din[i];
          dout[i]   <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule : embps_sync

// [hdl/embps_pin_share.sv]
`include "embps_defines.svh"

module embps_pin_share
(
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire embps_pkg::embps_owner_t  owner,
  input  wire embps_pkg::embps_mem_req_t   mem_req,
  input  wire embps_pkg::embps_sdram_req_t sdram_req,
  input  wire embps_pkg::embps_card_req_t  card_req,
  input  wire logic [1:0]               function_mux_control,
  input  wire logic                     ack_mode,
  input  wire logic                     cs4_pin_in,
  input  wire logic                     burst_restart_n,
  input  wire logic                     burst_clk_src,
  input  wire logic [3:0]               boot_pins,
  output embps_pkg::embps_pins_t        pins,
  output logic                          transfer_ack_in_n,
  output logic                          burst_restart_seen,
  output logic [3:0]                    boot_mode,
  output logic                          boot_strap_bad
);
  import embps_pkg::*;

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic       ack_s;
  logic       restart_s;
  logic       bclk_s;
  logic [3:0] boot_s;

  embps_sync #(.W(1)) u_sync_ack
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (cs4_pin_in),
    .dout    (ack_s)
  );

  embps_sync #(.W(1)) u_sync_restart
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (burst_restart_n),
    .dout    (restart_s)
  );

  // Burst clock source is a link clock; sampled, edges found below
  embps_sync #(.W(1)) u_sync_bclk
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (burst_clk_src),
    .dout    (bclk_s)
  );

  embps_sync #(.W(`EMBPS_BOOT_W)) u_sync_boot
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (boot_pins),
    .dout    (boot_s)
  );

  // ----------------------------------------
  // Boot strap capture
  // ----------------------------------------
  logic       boot_taken_r;
  logic [1:0] boot_wait_r;
  logic [1:0] boot_wait_nxt;
  logic       boot_take;

  // Wait for the synchroniser to fill with post-reset samples
  assign boot_take     = !boot_taken_r && (boot_wait_r == 2'h2);
  assign boot_wait_nxt = boot_taken_r ? boot_wait_r : boot_wait_r + 2'h1;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      boot_taken_r <= 1'b0;
      boot_wait_r  <= 2'h0;
      boot_mode    <= `EMBPS_RST_BOOT;
    end
    else
    begin
      boot_wait_r <= boot_wait_nxt;
      if (boot_take)
      begin
        boot_taken_r <= 1'b1;
        boot_mode    <= boot_s;
      end
    end
  end

  // Board fault flag; board must hold bit 3 low
  logic boot_bad_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      boot_bad_r <= 1'b0;
    else if (boot_take)
      boot_bad_r <= boot_s[`EMBPS_BOOT_RSVD];
  end
  assign boot_strap_bad = boot_bad_r;

  // ----------------------------------------
  // Acknowledge and burst restart
  // ----------------------------------------
  logic restart_d_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      restart_d_r <= 1'b1;
    else
      restart_d_r <= restart_s;
  end

  // Falling edge is one restart request; controller starts a long access
  assign burst_restart_seen = restart_d_r && !restart_s;
  // Acknowledge only meaningful while select 4 is an input
  assign transfer_ack_in_n  = ack_mode ? ack_s : 1'b1;

  // ----------------------------------------
  // Burst clock edge tracking
  // ----------------------------------------
  // Reset level matches the synchroniser's, so no false edge after reset
  logic bclk_d_r;
  logic bclk_nxt;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      bclk_d_r <= 1'b1;
    else
      bclk_d_r <= bclk_s;
  end

  // Follow each sampled source edge; held low outside bursts
  assign bclk_nxt = !mem_req.burst_active ? 1'b0 :
                    (bclk_s != bclk_d_r)  ? bclk_s :
                    pins.burst_clk;

  // ----------------------------------------
  // Pin selection
  // ----------------------------------------
  wire sel_sdram = (owner == EMBPS_OWNER_SDRAM);
  wire sel_card  = (owner == EMBPS_OWNER_CARD);

  // Mask bit 3 sits on data 31:24, so reverse onto lane pins
  wire [3:0] dqm_on_lanes = {sdram_req.dqm[0], sdram_req.dqm[1],
                             sdram_req.dqm[2], sdram_req.dqm[3]};

  // Card owns only lanes 2 and 3; lanes 0 and 1 idle high
  wire [3:0] lane_card      = {card_req.iord_n, card_req.reg_n, 2'h3};
  // Vector bit index is the lane number, so no reordering here
  wire [3:0] lane_card_pins = lane_card;

  wire [3:0] lane_nxt = sel_sdram ? dqm_on_lanes :
                        sel_card  ? lane_card_pins :
                        mem_req.byte_lane_enable_n;

  wire oe_nxt = sel_card  ? card_req.iowr_n :
                sel_sdram ? 1'b1 : mem_req.oe_n;
  wire rw_nxt = sel_card  ? card_req.we_n :
                sel_sdram ? 1'b1 : mem_req.rw;

  // Selects 2 and 3 taken from SDRAM when the control bit is set
  logic [5:0] cs_nxt;
  logic [5:0] cs_oe_nxt;
  genvar k;
  generate
    for (k = 0; k < `EMBPS_CS_W; k++)
    begin : g_cs
      if (k == `EMBPS_CS_SDRAM_LO || k == `EMBPS_CS_SDRAM_LO + 1)
      begin : g_shared
        assign cs_nxt[k] = function_mux_control[k - `EMBPS_CS_SDRAM_LO] ?
                           sdram_req.sdram_chip_select_n[k - `EMBPS_CS_SDRAM_LO] :
                           mem_req.cs_n[k];
        assign cs_oe_nxt[k] = 1'b1;
      end
      else if (k == `EMBPS_CS_ACK)
      begin : g_ack
        assign cs_nxt[k]    = mem_req.cs_n[k];
        assign cs_oe_nxt[k] = !ack_mode;
      end
      else
      begin : g_plain
        assign cs_nxt[k]    = mem_req.cs_n[k];
        assign cs_oe_nxt[k] = 1'b1;
      end
    end
  endgenerate

  // Address pins: SDRAM fields overlay memory address in SDRAM ownership
  logic [25:0] addr_sdram;
  always_comb
  begin
    addr_sdram = mem_req.addr;
    addr_sdram[`EMBPS_RC_A_LSB +: `EMBPS_RC_SHARED_W] =
      sdram_req.sdram_row_col_addr[`EMBPS_RC_SHARED_W-1:0];
    if (sdram_req.bank_mode == EMBPS_BANK_FLAT)
      addr_sdram[`EMBPS_FLAT_LSB +: `EMBPS_FLAT_W] = sdram_req.sdram_bank_sel_flat;
    else
      addr_sdram[`EMBPS_ILV_LSB +: `EMBPS_ILV_W] =
        sdram_req.sdram_bank_sel_interleaved;
  end

  wire [25:0] addr_nxt = sel_sdram ? addr_sdram : mem_req.addr;

  // ----------------------------------------
  // Registered pin drivers
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pins.byte_lane_enable_n <= 4'hF;
      pins.oe_n               <= 1'b1;
      pins.rw                 <= 1'b1;
      pins.cs_n               <= 6'h3F;
      pins.cs_oe              <= 6'h3F;
      pins.burst_addr_latch_n <= 1'b1;
      pins.burst_clk          <= 1'b0;
      pins.addr               <= 26'h0000000;
    end
    else
    begin
      pins.byte_lane_enable_n <= lane_nxt;
      pins.oe_n               <= oe_nxt;
      pins.rw                 <= rw_nxt;
      pins.cs_n               <= cs_nxt;
      pins.cs_oe              <= cs_oe_nxt;
      pins.burst_addr_latch_n <= (owner == EMBPS_OWNER_MEM) ?
                                 mem_req.burst_addr_latch_n : 1'b1;
      pins.burst_clk          <= bclk_nxt;
      pins.addr               <= addr_nxt;
    end
  end

endmodule : embps_pin_share

// [tb/embps_pin_share_monitor.sv]
module embps_pin_share_monitor
(
  input wire logic                        clk_sys,
  input wire logic                        reset,
  input wire embps_pkg::embps_owner_t     owner,
  input wire embps_pkg::embps_mem_req_t   mem_req,
  input wire embps_pkg::embps_sdram_req_t sdram_req,
  input wire embps_pkg::embps_card_req_t  card_req,
  input wire logic [1:0]                  function_mux_control,
  input wire logic                        ack_mode,
  input wire logic                        cs4_pin_in,
  input wire logic                        burst_restart_n,
  input wire logic                        burst_clk_src,
  input wire logic [3:0]                  boot_pins,
  input wire embps_pkg::embps_pins_t      pins,
  input wire logic                        transfer_ack_in_n,
  input wire logic                        burst_restart_seen,
  input wire logic [3:0]                  boot_mode,
  input wire logic                        boot_strap_bad
);
  timeunit 1ns;
  timeprecision 100ps;
  import embps_pkg::*;
  // ----------------------------------------
  // Expected shared pin values
  // ----------------------------------------
  wire logic [3:0] dqm_pin = {sdram_req.dqm[0], sdram_req.dqm[1],
                              sdram_req.dqm[2], sdram_req.dqm[3]};
  wire logic [1:0] cs_mid  = (function_mux_control & sdram_req.sdram_chip_select_n)
                           | (~function_mux_control & mem_req.cs_n[3:2]);
  wire logic       is_mem  = owner == EMBPS_OWNER_MEM;
  wire logic       is_sd   = owner == EMBPS_OWNER_SDRAM;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_mem_lanes: assert property (
    is_mem |=> pins.byte_lane_enable_n == $past(mem_req.byte_lane_enable_n)) else $error("lane");
  a_dqm_lanes: assert property (
    is_sd |=> pins.byte_lane_enable_n == $past(dqm_pin)) else $error("mask lanes");
  a_card_pins: assert property (
    owner == EMBPS_OWNER_CARD |=> pins.byte_lane_enable_n == {$past(card_req.iord_n),
    $past(card_req.reg_n), 2'h3} && pins.oe_n == $past(card_req.iowr_n)) else $error("card");
  a_mem_ctrl: assert property (
    is_mem |=> pins.oe_n == $past(mem_req.oe_n) && pins.rw == $past(mem_req.rw)
    && pins.burst_addr_latch_n == $past(mem_req.burst_addr_latch_n)) else $error("mem ctrl");
  a_cs_select: assert property (
    1'b1 |=> pins.cs_n[3:2] == $past(cs_mid)) else $error("select mux");
  a_ack_input: assert property (
    (ack_mode && !cs4_pin_in) [*3] |-> !transfer_ack_in_n) else $error("ack lost");
  a_ack_idle: assert property (
    !ack_mode |-> transfer_ack_in_n) else $error("ack idle");
  a_restart_pulse: assert property (
    $fell(burst_restart_n) |-> ##[2:3] burst_restart_seen ##1 !burst_restart_seen)
    else $error("restart pulse");
  a_burst_idle: assert property (
    !mem_req.burst_active |=> !pins.burst_clk) else $error("burst clock idle");
  a_bank_flat: assert property (
    is_sd && sdram_req.bank_mode == EMBPS_BANK_FLAT |=> pins.addr[20:16] ==
    $past(sdram_req.sdram_bank_sel_flat)
    && pins.addr[10:1] == $past(sdram_req.sdram_row_col_addr[9:0]))
    else $error("flat bank");
  a_bank_ilv: assert property (
    is_sd && sdram_req.bank_mode == EMBPS_BANK_INTERLEAVED |=> pins.addr[24:21] ==
    $past(sdram_req.sdram_bank_sel_interleaved)) else $error("interleaved bank");
  a_sdram_quiet: assert property (
    is_sd |=> pins.oe_n && pins.rw) else $error("sdram drove oe or rw");
  c_restart: cover property (burst_restart_seen);
  c_card: cover property (owner == EMBPS_OWNER_CARD);
  c_ack: cover property (ack_mode && !transfer_ack_in_n);
endmodule : embps_pin_share_monitor

bind embps_pin_share embps_pin_share_monitor u_mon (.clk_sys, .reset, .owner, .mem_req,
  .sdram_req, .card_req, .function_mux_control, .ack_mode, .cs4_pin_in, .burst_restart_n,
  .burst_clk_src, .boot_pins, .pins, .transfer_ack_in_n, .burst_restart_seen, .boot_mode,
  .boot_strap_bad);

// [tb/embps_far_model.sv]
module embps_far_model
(
  input  wire logic  cs4_drive,
  input  wire logic  cs4_level,
  input  wire logic  ack_req,
  input  wire logic  restart_req,
  input  wire logic  burst_on,
  output logic       cs4_pin_in,
  output logic       burst_restart_n,
  output logic       burst_clk_src,
  output logic [3:0] boot_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Block wins the shared pin while it drives it
  assign cs4_pin_in      = cs4_drive ? cs4_level : !ack_req;
  assign burst_restart_n = !restart_req;
  // Straps fixed from power-up, top bit low
  assign boot_pins       = 4'h5;
  // Link clock stands still outside bursts
  initial
  begin
    burst_clk_src = 1'h0;
    #3;
    forever
    begin
      #40;
      burst_clk_src = burst_on ? !burst_clk_src : 1'h0;
    end
  end
endmodule : embps_far_model

// [tb/embps_pin_share_tb.sv]
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
`define WAITV(x, v) i = 0; while ((x) !== (v)) begin step(1); \
  if (++i > 60) begin n_fail++; complete_run(); end end

module embps_pin_share_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import embps_pkg::*;
  logic             clk_sys, reset, ack_mode, ack_req, restart_req, burst_on;
  logic [1:0]       function_mux_control, exp_cs;
  embps_owner_t     owner;
  embps_mem_req_t   mem_req;
  embps_sdram_req_t sdram_req;
  embps_card_req_t  card_req;
  embps_pins_t      pins;
  logic             cs4_pin_in, burst_restart_n, burst_clk_src, transfer_ack_in_n;
  logic             burst_restart_seen, boot_strap_bad;
  logic [3:0]       boot_pins, boot_mode;
  int               n_fail, total_checks, i;

  embps_pin_share DUT (.clk_sys, .reset, .owner, .mem_req, .sdram_req, .card_req,
    .function_mux_control, .ack_mode, .cs4_pin_in, .burst_restart_n, .burst_clk_src,
    .boot_pins, .pins, .transfer_ack_in_n, .burst_restart_seen, .boot_mode, .boot_strap_bad);
  embps_far_model u_far (.cs4_drive(pins.cs_oe[4]), .cs4_level(pins.cs_n[4]), .ack_req,
    .restart_req, .burst_on, .cs4_pin_in, .burst_restart_n, .burst_clk_src, .boot_pins);

  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task t_reset;
    `CHK("cs_oe", 6'h3F, pins.cs_oe)
    `CHK("boot_mode", 4'h5, boot_mode)
    `CHK("strap_bad", 1'h0, boot_strap_bad)
    $display("test reset done");
  endtask : t_reset

  task t_mem;
    mem_req = '{4'h6, 1'h0, 1'h0, 6'h3E, 1'h0, 1'h0, 26'h2ABCDEF};
    step(1);
    `CHK("lanes", 4'h6, pins.byte_lane_enable_n)
    `CHK("oe_n", 1'h0, pins.oe_n)
    `CHK("rw", 1'h0, pins.rw)
    `CHK("latch", 1'h0, pins.burst_addr_latch_n)
    `CHK("addr", 26'h2ABCDEF, pins.addr)
    mem_req.rw = 1'h1;
    step(1);
    `CHK("rw", 1'h1, pins.rw)
    $display("test mem done");
  endtask : t_mem

  task t_sdram;
    owner     = EMBPS_OWNER_SDRAM;
    sdram_req = '{4'h1, 2'h2, 5'h15, 4'hA, 12'hA5B, EMBPS_BANK_FLAT};
    step(1);
    `CHK("dqm lanes", 4'h8, pins.byte_lane_enable_n)
    `CHK("oe_n", 1'h1, pins.oe_n)
    `CHK("flat", 5'h15, pins.addr[20:16])
    `CHK("rowcol", 10'h25B, pins.addr[10:1])
    sdram_req.bank_mode = EMBPS_BANK_INTERLEAVED;
    step(1);
    `CHK("ilv", 4'hA, pins.addr[24:21])
    $display("test sdram done");
  endtask : t_sdram

  task t_card;
    owner    = EMBPS_OWNER_CARD;
    card_req = '{1'h0, 1'h1, 1'h0, 1'h1};
    step(1);
    `CHK("card lanes", 4'hB, pins.byte_lane_enable_n)
    `CHK("card oe", 1'h0, pins.oe_n)
    `CHK("card rw", 1'h1, pins.rw)
    $display("test card done");
  endtask : t_card

  task t_cs;
    // SDRAM selects differ from the memory selects on both pins
    sdram_req.sdram_chip_select_n = 2'h0;
    for (int fm = 0; fm < 4; fm++)
    begin
      function_mux_control = fm[1:0];
      exp_cs = (fm[1:0] & sdram_req.sdram_chip_select_n) | (~fm[1:0] & mem_req.cs_n[3:2]);
      step(1);
      `CHK("cs mid", exp_cs, pins.cs_n[3:2])
    end
    $display("test select done");
  endtask : t_cs

  task t_ack;
    ack_mode = 1'h1;
    ack_req  = 1'h1;
    `WAITV(transfer_ack_in_n, 1'h0)
    `CHK("cs4 oe", 1'h0, pins.cs_oe[4])
    ack_mode = 1'h0;
    step(1);
    `CHK("ack idle", 1'h1, transfer_ack_in_n)
    `CHK("cs4 oe", 1'h1, pins.cs_oe[4])
    ack_req = 1'h0;
    $display("test ack done");
  endtask : t_ack

  task t_burst;
    owner                = EMBPS_OWNER_MEM;
    mem_req.burst_active = 1'h1;
    burst_on             = 1'h1;
    `WAITV(pins.burst_clk, 1'h1)
    `WAITV(pins.burst_clk, 1'h0)
    restart_req = 1'h1;
    `WAITV(burst_restart_seen, 1'h1)
    step(1);
    `CHK("restart pulse", 1'h0, burst_restart_seen)
    restart_req          = 1'h0;
    burst_on             = 1'h0;
    mem_req.burst_active = 1'h0;
    step(2);
    `CHK("bclk idle", 1'h0, pins.burst_clk)
    $display("test burst done");
  endtask : t_burst

  initial
  begin
    clk_sys = 1'h0;
    forever #4 clk_sys = !clk_sys;
  end

  initial
  begin
    reset = 1'h1;
    owner = EMBPS_OWNER_MEM;
    mem_req = '{4'hF, 1'h1, 1'h1, 6'h3F, 1'h1, 1'h0, 26'h0};
    sdram_req = '1;
    card_req = '1;
    function_mux_control = 2'h3;
    {ack_mode, ack_req, restart_req, burst_on} = 4'h0;
    n_fail = 0;
    total_checks = 0;
    step(20);
    reset = 1'h0;
    step(4);
    t_reset();
    t_mem();
    t_sdram();
    t_card();
    t_cs();
    t_ack();
    t_burst();
    complete_run();
  end
endmodule : embps_pin_share_tb
